// *** logic/ppgcu_pkg.sv ***
// Purpose: constants and types for the compare update control of a pulse-pattern timer pair
// Assumes: byte addresses on an 8-bit register port, 32-bit data
// Notes: slot index is addr[3:2], so at most four compare slots per timer
package ppgcu_pkg;
  localparam int ADDR_W = 8;
  localparam int IDX_W = 2;

  localparam logic [7:0] CTRL0_OFS = 8'h00;
  localparam logic [7:0] CTRL1_OFS = 8'h04;
  localparam logic [7:0] CFG_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;
  localparam logic [7:0] BUF0_OFS = 8'h10;
  localparam logic [7:0] BUF1_OFS = 8'h20;
  localparam logic [7:0] CMP0_OFS = 8'h30;
  localparam logic [7:0] CMP1_OFS = 8'h40;

  // ppg_timer_control layout
  localparam int CTRL_W = 12;
  localparam logic [11:0] CTRL_WMASK = 12'hFF7;
  localparam logic [11:0] CTRL_RESET = 12'h000;
  localparam int WPATH_BIT = 2;
  localparam int UPD_SEL_BIT = 4;
  localparam int MODCY_LSB = 5;
  localparam logic [2:0] MODCY_NONE = 3'h0;
  localparam logic [2:0] MODCY_MAX = 3'h4;

  // configuration register layout
  localparam int CFG_W = 10;
  localparam logic [9:0] CFG_WMASK = 10'h337;
  localparam logic [9:0] CFG_RESET = 10'h000;
  localparam int PAIR_LSB = 0;
  localparam int PPG0_BIT = 4;
  localparam int MCLR0_BIT = 8;
  localparam logic [2:0] PAIR_IPPG_A = 3'h6;
  localparam logic [2:0] PAIR_IPPG_B = 3'h7;

  typedef struct packed {
    logic [1:0][CTRL_W-1:0] ctrl;
    logic [CFG_W-1:0] cfg;
    logic [1:0] eff_sel;
    logic [31:0] rdata;
  } ppgcu_state_t;
endpackage

// *** logic/ppgcu_bank_if.sv ***
// Purpose: carries one timer's buffer writes and transfer strobes to its compare bank
// Assumes: single clock domain
// Notes: plain signals only, no clocking
`timescale 1ns/1ps
interface ppgcu_bank_if #(
  parameter int W = 16,
  parameter int N = 4
);
  logic wr_en;
  logic [1:0] wr_idx;
  logic [W-1:0] wr_data;
  logic direct;
  logic xfer;
  logic [N-1:0][W-1:0] hold;
  logic [N-1:0][W-1:0] cmp;
  modport ctl (output wr_en, wr_idx, wr_data, direct, xfer, input hold, cmp);
  modport bank (input wr_en, wr_idx, wr_data, direct, xfer, output hold, cmp);
endinterface

// *** logic/ppgcu_bank.sv ***
// Purpose: buffer and compare registers of one timer
// Assumes: wr_idx is below N whenever wr_en is high
// Notes: the compare values leave straight from flip-flops
`timescale 1ns/1ps
module ppgcu_bank import ppgcu_pkg::*; #(
  parameter int W = 16,
  parameter int N = 4
) (
  input wire logic clk_i,
  input wire logic reset_i,
  ppgcu_bank_if.bank bif
);
  typedef struct packed {
    logic [N-1:0][W-1:0] hold;
    logic [N-1:0][W-1:0] cmp;
  } ppgcu_bank_t;

  ppgcu_bank_t st;
  ppgcu_bank_t next_st;

  always_comb begin
    next_st = st;
    // a staged write landing with the transfer goes to the buffer only; the
    // compare takes the older buffer value, so no slot is half updated
    if (bif.xfer && !bif.direct) begin
      next_st.cmp = st.hold;
    end
    if (bif.wr_en) begin
      next_st.hold[bif.wr_idx] = bif.wr_data;
      if (bif.direct) begin
        next_st.cmp[bif.wr_idx] = bif.wr_data;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bif.hold = st.hold;
  assign bif.cmp = st.cmp;
endmodule // ppgcu_bank

// *** logic/ppgcu_top.sv ***
// Purpose: compare register load control for a pulse-pattern timer pair
// Assumes: event inputs are one-cycle pulses synchronous to clk_i
// Notes: timer 1 has its own registers but follows timer 0's write path bit in interlocked PPG
`timescale 1ns/1ps
module ppgcu_top import ppgcu_pkg::*; #(
  parameter int CMP_W = 16,
  parameter int SLOTS = 4
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [1:0] ovf_i,
  input wire logic [1:0] pmatch_i,
  input wire logic [1:0] modcyc_end_i,
  output logic [31:0] rdata_o,
  output logic [SLOTS-1:0][CMP_W-1:0] cmp0_o,
  output logic [SLOTS-1:0][CMP_W-1:0] cmp1_o,
  output logic [1:0] upd_sel_o
);
  ppgcu_state_t st;
  ppgcu_state_t next_st;
  logic ippg;
  logic [1:0] ppg;
  logic [1:0] wpath;
  logic [1:0] upd_evt;
  logic [1:0] buf_hit;
  logic [1:0] cmp_hit;
  logic [IDX_W-1:0] idx;
  logic idx_ok;

  ppgcu_bank_if #(.W(CMP_W), .N(SLOTS)) b0 ();
  ppgcu_bank_if #(.W(CMP_W), .N(SLOTS)) b1 ();

  // codes above the last valid one are prohibited; treat them as no modulation
  function automatic logic mod_none(input logic [2:0] code);
    return (code == MODCY_NONE) || (code > MODCY_MAX);
  endfunction

  function automatic logic blk_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
    return a[ADDR_W-1:4] == base[ADDR_W-1:4];
  endfunction

  function automatic logic [31:0] word(input logic [CMP_W-1:0] v);
    logic [31:0] w;
    w = '0;
    w[CMP_W-1:0] = v;
    return w;
  endfunction

  assign idx = addr_i[3:2];
  assign idx_ok = ({30'h0, idx} < SLOTS) && (addr_i[1:0] == 2'h0);
  assign ippg = (st.cfg[PAIR_LSB+:3] == PAIR_IPPG_A) || (st.cfg[PAIR_LSB+:3] == PAIR_IPPG_B);

  always_comb begin
    for (int t = 0; t < 2; t++) begin
      ppg[t] = st.cfg[PPG0_BIT+t] | ippg;
      // timer modes move staged values on the period match alone
      if (!ppg[t]) begin
        upd_evt[t] = pmatch_i[t];
      end else if (st.eff_sel[t] || mod_none(st.ctrl[t][MODCY_LSB+:3])) begin
        upd_evt[t] = pmatch_i[t];
      end else begin
        upd_evt[t] = modcyc_end_i[t];
      end
    end
    wpath[0] = st.ctrl[0][WPATH_BIT];
    // interlocked pair: the second timer's own path bit is ignored
    wpath[1] = ippg ? st.ctrl[0][WPATH_BIT] : st.ctrl[1][WPATH_BIT];
    buf_hit[0] = blk_hit(addr_i, BUF0_OFS) && idx_ok;
    buf_hit[1] = blk_hit(addr_i, BUF1_OFS) && idx_ok;
    cmp_hit[0] = blk_hit(addr_i, CMP0_OFS) && idx_ok;
    cmp_hit[1] = blk_hit(addr_i, CMP1_OFS) && idx_ok;
  end

  assign b0.wr_en = wr_i && buf_hit[0];
  assign b1.wr_en = wr_i && buf_hit[1];
  assign b0.wr_idx = idx;
  assign b1.wr_idx = idx;
  assign b0.wr_data = wdata_i[CMP_W-1:0];
  assign b1.wr_data = wdata_i[CMP_W-1:0];
  assign b0.direct = !wpath[0];
  assign b1.direct = !wpath[1];
  assign b0.xfer = wpath[0] && upd_evt[0];
  assign b1.xfer = wpath[1] && upd_evt[1];

  ppgcu_bank #(.W(CMP_W), .N(SLOTS)) u_bank0 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .bif(b0)
  );

  ppgcu_bank #(.W(CMP_W), .N(SLOTS)) u_bank1 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .bif(b1)
  );

  always_comb begin
    next_st = st;
    next_st.rdata = '0;
    // the written select waits for its load event, so a cycle in flight
    // never switches its transfer timing halfway
    for (int t = 0; t < 2; t++) begin
      if (st.cfg[MCLR0_BIT+t] ? pmatch_i[t] : ovf_i[t]) begin
        next_st.eff_sel[t] = st.ctrl[t][UPD_SEL_BIT];
      end
    end
    if (wr_i) begin
      case (addr_i)
        CTRL0_OFS: next_st.ctrl[0] = wdata_i[CTRL_W-1:0] & CTRL_WMASK;
        CTRL1_OFS: next_st.ctrl[1] = wdata_i[CTRL_W-1:0] & CTRL_WMASK;
        CFG_OFS: next_st.cfg = wdata_i[CFG_W-1:0] & CFG_WMASK;
        default: next_st.cfg = st.cfg;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        CTRL0_OFS: next_st.rdata = {20'h0, st.ctrl[0]};
        CTRL1_OFS: next_st.rdata = {20'h0, st.ctrl[1]};
        CFG_OFS: next_st.rdata = {22'h0, st.cfg};
        STAT_OFS: next_st.rdata = {26'h0, wpath, ppg, st.eff_sel};
        default: begin
          if (buf_hit[0]) begin
            next_st.rdata = word(b0.hold[idx]);
          end else if (buf_hit[1]) begin
            next_st.rdata = word(b1.hold[idx]);
          end else if (cmp_hit[0]) begin
            next_st.rdata = word(b0.cmp[idx]);
          end else if (cmp_hit[1]) begin
            next_st.rdata = word(b1.cmp[idx]);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st.ctrl <= {CTRL_RESET, CTRL_RESET};
      st.cfg <= CFG_RESET;
      st.eff_sel <= 2'h0;
      st.rdata <= 32'h0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign upd_sel_o = st.eff_sel;
  assign cmp0_o = b0.cmp;
  assign cmp1_o = b1.cmp;
endmodule // ppgcu_top

// *** verification/ppgcu_checker.sv ***
// Purpose: port-level checks of the compare update control
// Assumes: one clock, synchronous reset
// Notes: shadows timer 0 control and config writes to know the write path
`timescale 1ns/1ps
module ppgcu_checker import ppgcu_pkg::*; #(
  parameter int CMP_W = 16,
  parameter int SLOTS = 4
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [1:0] ovf_i,
  input wire logic [1:0] pmatch_i,
  input wire logic [1:0] modcyc_end_i,
  input wire logic [31:0] rdata_o,
  input wire logic [SLOTS-1:0][CMP_W-1:0] cmp0_o,
  input wire logic [SLOTS-1:0][CMP_W-1:0] cmp1_o,
  input wire logic [1:0] upd_sel_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic [11:0] c0;
  logic [9:0] cf;
  wire ilk = cf[2:1] == 2'b11;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      c0 <= '0;
      cf <= '0;
    end else if (wr_i && addr_i == CTRL0_OFS) begin
      c0 <= wdata_i[11:0] & CTRL_WMASK;
    end else if (wr_i && addr_i == CFG_OFS) begin
      cf <= wdata_i[9:0] & CFG_WMASK;
    end
  end
  rd_zero_a: assert property (!rd_i |=> rdata_o == 32'h0) else $error("stray read data");
  rsvd_bit_a: assert property (rd_i && addr_i == CTRL0_OFS |=> rdata_o[3] == 1'b0)
    else $error("reserved bit set");
  direct_copy_a: assert property (wr_i && addr_i == BUF0_OFS && !c0[WPATH_BIT]
    |=> cmp0_o[0] == $past(wdata_i[CMP_W-1:0])) else $error("direct write not copied");
  staged_hold_a: assert property (c0[WPATH_BIT] && !(pmatch_i[0] || modcyc_end_i[0])
    |=> $stable(cmp0_o)) else $error("staged compare moved without event");
  ev_gate_a: assert property (c0[WPATH_BIT] && !pmatch_i[0]
    && (c0[7:5] == MODCY_NONE || c0[7:5] > MODCY_MAX || !(cf[PPG0_BIT] || ilk))
    |=> $stable(cmp0_o))
    else $error("compare moved without period match");
  sel_hold_a: assert property (!ovf_i[0] && !pmatch_i[0] |=> $stable(upd_sel_o[0]))
    else $error("select changed without load event");
  sel_load_a: assert property ((cf[MCLR0_BIT] ? pmatch_i[0] : ovf_i[0])
    |=> upd_sel_o[0] == $past(c0[UPD_SEL_BIT])) else $error("select not loaded");
  ilk_path_a: assert property (ilk && c0[WPATH_BIT] && !(pmatch_i[1] || modcyc_end_i[1])
    |=> $stable(cmp1_o)) else $error("timer1 ignored timer0 write path");
  cover property (pmatch_i[0] && c0[WPATH_BIT]);
  cover property (ilk && wr_i && addr_i == BUF1_OFS);
  cover property (pmatch_i[0] && cf[MCLR0_BIT]);
endmodule // ppgcu_checker

bind ppgcu_top ppgcu_checker #(.CMP_W(CMP_W), .SLOTS(SLOTS)) chk (.clk_i(clk_i),
  .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .ovf_i(ovf_i), .pmatch_i(pmatch_i), .modcyc_end_i(modcyc_end_i), .rdata_o(rdata_o),
  .cmp0_o(cmp0_o), .cmp1_o(cmp1_o), .upd_sel_o(upd_sel_o));

// *** verification/test_ppgcu_top.sv ***
// Purpose: self-checking bench for the compare update control
// Assumes: default parameters, 40 MHz clock
// Notes: no handshakes, so every wait is a fixed cycle count
`timescale 1ns/1ps
module test_ppgcu_top import ppgcu_pkg::*;;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} ppgcu_row_t;
  logic clk_i, reset_i, wr_i, rd_i;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [1:0] ovf_i, pmatch_i, modcyc_end_i, upd_sel_o;
  logic [3:0][15:0] cmp0_o, cmp1_o;
  int fails, cmp_count;
  ppgcu_row_t rows [4] = '{'{CTRL0_OFS, 32'hFFFF_FFFF, 32'(CTRL_WMASK)},
    '{CTRL1_OFS, 32'hFFFF_FFFF, 32'(CTRL_WMASK)}, '{CFG_OFS, 32'hFFFF_FFFF, 32'(CFG_WMASK)},
    '{8'hFC, 32'hFFFF_FFFF, 32'h0}};
  ppgcu_top dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .ovf_i(ovf_i), .pmatch_i(pmatch_i), .modcyc_end_i(modcyc_end_i),
    .rdata_o(rdata_o), .cmp0_o(cmp0_o), .cmp1_o(cmp1_o), .upd_sel_o(upd_sel_o));
  initial begin
    clk_i = 0;
    forever #12.5 clk_i = ~clk_i;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask
  // k: 0 overflow, 1 period match, 2 modulation cycle end
  task ev(input logic [1:0] m, input int k);
    @(posedge clk_i);
    case (k)
      0: ovf_i <= m;
      1: pmatch_i <= m;
      default: modcyc_end_i <= m;
    endcase
    @(posedge clk_i);
    ovf_i <= 2'h0; pmatch_i <= 2'h0; modcyc_end_i <= 2'h0;
    #1;
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    reset_i = 1; wr_i = 0; rd_i = 0; addr_i = 0; wdata_i = 0;
    ovf_i = 0; pmatch_i = 0; modcyc_end_i = 0;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    $display("test register map done");
    wr(CTRL0_OFS, 32'h0); wr(CTRL1_OFS, 32'h0); wr(CFG_OFS, 32'h0);
    wr(BUF0_OFS + 8'h04, 32'h1234);
    chk(32'(cmp0_o[1]), 32'h1234);
    rd(CMP0_OFS + 8'h04, 32'h1234);
    $display("test direct path done");
    wr(CTRL0_OFS, 32'h14); wr(CFG_OFS, 32'h10); ev(2'h1, 0);
    chk(32'(upd_sel_o[0]), 32'h1);
    wr(BUF0_OFS, 32'h7); wr(BUF0_OFS + 8'h08, 32'h9);
    chk(32'(cmp0_o[0]), 32'h0);
    ev(2'h1, 2);
    chk(32'(cmp0_o[2]), 32'h0);
    ev(2'h1, 1);
    chk({cmp0_o[2], cmp0_o[0]}, 32'h0009_0007);
    wr(CTRL0_OFS, 32'h24); ev(2'h1, 0);
    chk(32'(upd_sel_o[0]), 32'h0);
    wr(BUF0_OFS, 32'hA); ev(2'h1, 2);
    chk(32'(cmp0_o[0]), 32'hA);
    wr(CTRL0_OFS, 32'h04); wr(BUF0_OFS, 32'hB); ev(2'h1, 2);
    chk(32'(cmp0_o[0]), 32'hA);
    ev(2'h1, 1);
    chk(32'(cmp0_o[0]), 32'hB);
    $display("test staged path done");
    wr(CTRL1_OFS, 32'h04);
    wr(CFG_OFS, 32'h36); wr(BUF1_OFS, 32'h55);
    rd(STAT_OFS, 32'h3C);
    chk(32'(cmp1_o[0]), 32'h0);
    ev(2'h2, 1);
    chk(32'(cmp1_o[0]), 32'h55);
    wr(CTRL0_OFS, 32'h14); wr(CFG_OFS, 32'h110); ev(2'h1, 0);
    chk(32'(upd_sel_o[0]), 32'h0);
    ev(2'h1, 1);
    chk(32'(upd_sel_o[0]), 32'h1);
    $display("test interlock and match clear done");
    @(posedge clk_i);
    reset_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk({cmp0_o[0], 14'h0, upd_sel_o}, 32'h0);
    reset_i <= 1'b0;
    $display("test reset done");
    tally_and_finish();
  end
endmodule // test_ppgcu_top
